/* File: common/fth_pkg.sv */
package fth_pkg;

	// ************************************************************
	// word geometry and buffering
	// ************************************************************
	localparam int DATA_W = 5;
	localparam int DEV_DEPTH = 64;
	localparam int BUF_DEPTH = 8;
	localparam int CNT_W = 4;

	// ************************************************************
	// clock in MHz, pin timing figures in ns
	// ************************************************************
	localparam int CLK_MHZ = 10;
	localparam int T_PUSH_HIGH_NS = 30;
	localparam int T_PUSH_LOW_NS = 15;
	localparam int T_DATA_HOLD_NS = 35;
	localparam int T_POP_HIGH_NS = 28;
	localparam int T_POP_LOW_NS = 18;
	localparam int T_CLEAR_NS = 40;
	localparam int T_CLEAR_TO_PUSH_NS = 45;

	// least time rounded up to whole cycles, never under one
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [CNT_W-1:0] PUSH_HIGH_CYC = CNT_W'(cyc_min(T_PUSH_HIGH_NS));
	localparam logic [CNT_W-1:0] PUSH_LOW_CYC = CNT_W'(cyc_min(T_PUSH_LOW_NS));
	localparam logic [CNT_W-1:0] DATA_HOLD_CYC = CNT_W'(cyc_min(T_DATA_HOLD_NS));
	localparam logic [CNT_W-1:0] POP_HIGH_CYC = CNT_W'(cyc_min(T_POP_HIGH_NS));
	localparam logic [CNT_W-1:0] POP_LOW_CYC = CNT_W'(cyc_min(T_POP_LOW_NS));
	localparam logic [CNT_W-1:0] CLEAR_CYC = CNT_W'(cyc_min(T_CLEAR_NS));
	localparam logic [CNT_W-1:0] CLEAR_TO_PUSH_CYC = CNT_W'(cyc_min(T_CLEAR_TO_PUSH_NS));

	// ************************************************************
	// state encodings
	// ************************************************************
	typedef enum logic [1:0] {
		INIT_CLEAR,
		INIT_SETTLE,
		INIT_DONE
	} fth_init_t;

	typedef enum logic [1:0] {
		PUSH_IDLE,
		PUSH_HIGH,
		PUSH_LOW
	} fth_push_t;

	typedef enum logic [1:0] {
		POP_IDLE,
		POP_HIGH,
		POP_LOW
	} fth_pop_t;

endpackage

/* File: rtl/fth_buf.sv */
`timescale 1ns/1ps
module fth_buf #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic wr_fire;
	logic rd_fire;

	// ready and valid are registered flags, so both sides see honest levels
	assign wr_fire = wr_valid_in && wr_ready_out;
	assign rd_fire = rd_ready_in && rd_valid_out;
	assign rd_data_out = mem[rd_ptr_reg];

	// occupancy after this cycle's transfers
	always_comb begin
		count_next = count_reg;
		if (wr_fire && !rd_fire) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (rd_fire && !wr_fire) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	// storage writes, no reset needed on data
	always_ff @(posedge clk_in) begin
		if (wr_fire) begin
			mem[wr_ptr_reg] <= wr_data_in;
		end
	end

	// pointers, count and flags
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			wr_ready_out <= 1'b0;
			rd_valid_out <= 1'b0;
		end else if (flush_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			wr_ready_out <= 1'b0;
			rd_valid_out <= 1'b0;
		end else begin
			if (wr_fire) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
			end
			if (rd_fire) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
			end
			count_reg <= count_next;
			wr_ready_out <= (count_next != (AW+1)'(DEPTH));
			rd_valid_out <= (count_next != '0);
		end
	end

endmodule // fth_buf

/* File: rtl/fth_host.sv */
`timescale 1ns/1ps
// Overview of operation
// (RQ1) device takes push only with space_available high
// (RQ2) device ignores pushes while space_available low
// (RQ3) first stage drains, then space_available rises
// (RQ4) full device keeps space_available low
// (RQ5) word removed on pop strobe falling edge
// (RQ6) pop only while word_available high
// (RQ7) pop high drives word_available low
// (RQ8) next word ripples out, word_available rises
// (RQ9) last word popped: word_available stays low
// (RQ10) device ignores pops while word_available low
// (RQ11) capture output word before pop falls
// (RQ12) chained devices handshake among themselves
// (RQ13) wide banks combine flags with gates
// (RQ14) storage is 64 words of 4/5 bits
// (RQ15) clear forces space_available low until release
// (RQ16) strobe rate at most 12 MHz
// (RQ17) pulse clear_n low before first use
// (RQ18) push high loads word, space_available drops
// (RQ19) clear drives word_available low
// (RQ20) ripple modelled as a word queue with a lag counter
// (RQ21) device syncs strobes and detects edges
module fth_host (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clear_req_in,
	input wire logic [fth_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [fth_pkg::DATA_W-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic ready_out,
	output logic [fth_pkg::DATA_W-1:0] dev_data_out,
	output logic dev_push_out,
	input wire logic dev_space_available_in,
	input wire logic [fth_pkg::DATA_W-1:0] dev_data_in,
	output logic dev_pop_out,
	input wire logic dev_word_available_in,
	output logic dev_clear_n_out
);

	// ************************************************************
	// declarations
	// ************************************************************
	fth_pkg::fth_init_t init_reg;
	fth_pkg::fth_push_t push_reg;
	fth_pkg::fth_pop_t pop_reg;
	logic [fth_pkg::CNT_W-1:0] init_cnt_reg;
	logic [fth_pkg::CNT_W-1:0] push_cnt_reg;
	logic [fth_pkg::CNT_W-1:0] pop_cnt_reg;
	logic [fth_pkg::DATA_W-1:0] buf_data;
	logic buf_valid;
	logic buf_take;
	logic push_start;
	logic pop_start;
	logic both_idle;
	logic clear_start;

	// ************************************************************
	// write-side buffer
	// ************************************************************
	// words wait here while the device is busy; a full buffer stalls the writer
	fth_buf #(
		.WIDTH(fth_pkg::DATA_W),
		.DEPTH(fth_pkg::BUF_DEPTH)
	) u_buf (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.flush_in(clear_start),
		.wr_data_in(wr_data_in),
		.wr_valid_in(wr_valid_in),
		.wr_ready_out(wr_ready_out),
		.rd_data_out(buf_data),
		.rd_valid_out(buf_valid),
		.rd_ready_in(buf_take)
	);

	// ************************************************************
	// start conditions
	// ************************************************************
	// a clear only starts with both strobes low, never mid-handshake
	assign both_idle = (push_reg == fth_pkg::PUSH_IDLE) && (pop_reg == fth_pkg::POP_IDLE);
	assign clear_start = clear_req_in && both_idle && (init_reg == fth_pkg::INIT_DONE);
	// (RQ13) composite flags expected
	// (RQ1) push needs space
	assign push_start = (init_reg == fth_pkg::INIT_DONE) && !clear_req_in &&
		(push_reg == fth_pkg::PUSH_IDLE) && buf_valid && dev_space_available_in;
	assign buf_take = push_start;
	// (RQ6) pop needs word
	assign pop_start = (init_reg == fth_pkg::INIT_DONE) && !clear_req_in &&
		(pop_reg == fth_pkg::POP_IDLE) && dev_word_available_in && !rd_valid_out;

	// ************************************************************
	// clear sequence
	// ************************************************************
	// (RQ17) clear after reset
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			init_reg <= fth_pkg::INIT_CLEAR;
			init_cnt_reg <= '0;
			dev_clear_n_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			unique case (init_reg)
				fth_pkg::INIT_CLEAR: begin
					if (init_cnt_reg == fth_pkg::CLEAR_CYC - 4'h1) begin
						init_reg <= fth_pkg::INIT_SETTLE;
						init_cnt_reg <= '0;
						dev_clear_n_out <= 1'b1;
					end else begin
						init_cnt_reg <= init_cnt_reg + 4'h1;
					end
				end
				// clear release to first push
				fth_pkg::INIT_SETTLE: begin
					if (init_cnt_reg == fth_pkg::CLEAR_TO_PUSH_CYC - 4'h1) begin
						init_reg <= fth_pkg::INIT_DONE;
						init_cnt_reg <= '0;
						ready_out <= 1'b1;
					end else begin
						init_cnt_reg <= init_cnt_reg + 4'h1;
					end
				end
				fth_pkg::INIT_DONE: begin
					if (clear_start) begin
						init_reg <= fth_pkg::INIT_CLEAR;
						dev_clear_n_out <= 1'b0;
						ready_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// push handshake
	// ************************************************************
	// (RQ16) paced strobe widths
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			push_reg <= fth_pkg::PUSH_IDLE;
			push_cnt_reg <= '0;
			dev_push_out <= 1'b0;
			dev_data_out <= '0;
		end else begin
			unique case (push_reg)
				fth_pkg::PUSH_IDLE: begin
					if (push_start) begin
						push_reg <= fth_pkg::PUSH_HIGH;
						push_cnt_reg <= '0;
						dev_push_out <= 1'b1;
						dev_data_out <= buf_data; // data set up with the rising edge
					end
				end
				// (RQ18) wait for acceptance
				fth_pkg::PUSH_HIGH: begin
					if (push_cnt_reg != fth_pkg::PUSH_HIGH_CYC - 4'h1) begin
						push_cnt_reg <= push_cnt_reg + 4'h1;
					end else if (!dev_space_available_in) begin
						push_reg <= fth_pkg::PUSH_LOW;
						push_cnt_reg <= '0;
						dev_push_out <= 1'b0;
					end
				end
				// data held past the fall, and low time kept
				fth_pkg::PUSH_LOW: begin
					if (push_cnt_reg >= fth_pkg::DATA_HOLD_CYC - 4'h1 &&
						push_cnt_reg >= fth_pkg::PUSH_LOW_CYC - 4'h1) begin
						push_reg <= fth_pkg::PUSH_IDLE;
						push_cnt_reg <= '0;
					end else begin
						push_cnt_reg <= push_cnt_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// pop handshake
	// ************************************************************
	// only one word in flight: a pop waits until the reader has taken the last
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pop_reg <= fth_pkg::POP_IDLE;
			pop_cnt_reg <= '0;
			dev_pop_out <= 1'b0;
			rd_data_out <= '0;
		end else begin
			unique case (pop_reg)
				fth_pkg::POP_IDLE: begin
					if (pop_start) begin
						pop_reg <= fth_pkg::POP_HIGH;
						pop_cnt_reg <= '0;
						dev_pop_out <= 1'b1;
						// (RQ11) capture before fall
						rd_data_out <= dev_data_in;
					end
				end
				// (RQ7) flag drops while high
				fth_pkg::POP_HIGH: begin
					if (pop_cnt_reg != fth_pkg::POP_HIGH_CYC - 4'h1) begin
						pop_cnt_reg <= pop_cnt_reg + 4'h1;
					end else if (!dev_word_available_in) begin
						pop_reg <= fth_pkg::POP_LOW;
						pop_cnt_reg <= '0;
						dev_pop_out <= 1'b0;
					end
				end
				// (RQ5) word leaves on fall
				fth_pkg::POP_LOW: begin
					if (pop_cnt_reg == fth_pkg::POP_LOW_CYC - 4'h1) begin
						pop_reg <= fth_pkg::POP_IDLE;
						pop_cnt_reg <= '0;
					end else begin
						pop_cnt_reg <= pop_cnt_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// read-side valid
	// ************************************************************
	// word offered on the same edge the pop strobe falls; a new pop cannot start while set
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_valid_out <= 1'b0;
		end else if (pop_reg == fth_pkg::POP_HIGH && !dev_pop_out) begin
			rd_valid_out <= 1'b0;
		end else if (pop_reg == fth_pkg::POP_HIGH &&
			pop_cnt_reg == fth_pkg::POP_HIGH_CYC - 4'h1 && !dev_word_available_in) begin
			rd_valid_out <= 1'b1;
		end else if (rd_ready_in) begin
			rd_valid_out <= 1'b0;
		end
	end

endmodule // fth_host

/* File: tb/fth_dev_model.sv */
`timescale 1ns/1ps
// ********
// behavioural fall-through device
// ********
module fth_dev_model #(
	parameter int DEPTH = 64
) (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic clear_n_in,
	input wire logic push_in,
	input wire logic [fth_pkg::DATA_W-1:0] data_in,
	output logic space_available_out = 1'b0,
	input wire logic pop_in,
	output logic [fth_pkg::DATA_W-1:0] data_out = '0,
	output logic word_available_out = 1'b0
);
	logic [fth_pkg::DATA_W-1:0] mem_q[$];
	logic push_reg = 1'b0;
	logic pop_reg = 1'b0;
	logic pop_ok = 1'b0;
	int lag = 0;
	// stage ripple, self-timed
	// one ripple step per clock; slow mode lets flags rise only every fourth edge
	always @(posedge clk_in) begin
		push_reg <= push_in;
		pop_reg <= pop_in;
		lag <= (lag > 0) ? lag - 1 : (slow_in ? 3 : 0);
		if (!clear_n_in) begin
			mem_q.delete();
			pop_ok <= 1'b0;
			space_available_out <= 1'b0;
			word_available_out <= 1'b0;
		end else begin
			if (push_in && !push_reg && space_available_out) begin
				mem_q.push_back(data_in);
				space_available_out <= 1'b0;
			end else if (!push_in && mem_q.size() < DEPTH && lag == 0)
				space_available_out <= 1'b1;
			if (pop_in && !pop_reg && word_available_out) begin
				pop_ok <= 1'b1;
				word_available_out <= 1'b0;
			end else if (!pop_in && pop_reg && pop_ok) begin
				void'(mem_q.pop_front());
				pop_ok <= 1'b0;
				// scrambled while the next word ripples, so late capture shows up
				if (mem_q.size() > 0)
					data_out <= ~data_out;
			end else if (!pop_in && !pop_ok && !word_available_out && mem_q.size() > 0
				&& lag == 0) begin
				data_out <= mem_q[0];
				word_available_out <= 1'b1;
			end
		end
	end
endmodule // fth_dev_model

/* File: tb/fth_host_sva.sv */
`timescale 1ns/1ps
module fth_host_sva (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [fth_pkg::DATA_W-1:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic ready_out,
	input wire logic [fth_pkg::DATA_W-1:0] dev_data_out,
	input wire logic dev_push_out,
	input wire logic dev_space_available_in,
	input wire logic [fth_pkg::DATA_W-1:0] dev_data_in,
	input wire logic dev_pop_out,
	input wire logic dev_word_available_in,
	input wire logic dev_clear_n_out
);
	// ********
	// strobe and clear handshakes
	// ********
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_push_needs_space: assert property (
		$rose(dev_push_out) |-> $past(dev_space_available_in)) else $error("push without space");
	chk_push_fall_late: assert property (
		$fell(dev_push_out) |-> !$past(dev_space_available_in)) else $error("push fell early");
	chk_push_data_hold: assert property (
		$fell(dev_push_out) |-> (!dev_push_out && $stable(dev_data_out))[*2])
		else $error("push data not held");
	chk_pop_needs_word: assert property (
		$rose(dev_pop_out) |-> $past(dev_word_available_in) && !$past(rd_valid_out))
		else $error("pop without word");
	chk_pop_capture_word: assert property (
		$rose(dev_pop_out) |-> rd_data_out == $past(dev_data_in)) else $error("word not captured");
	chk_word_at_fall: assert property (
		$fell(dev_pop_out) |-> rd_valid_out) else $error("word not valid at pop fall");
	chk_clear_quiet: assert property (
		!dev_clear_n_out |-> !dev_push_out && !dev_pop_out) else $error("strobe during clear");
	chk_ready_after_clear: assert property (
		$rose(dev_clear_n_out) |-> !ready_out ##1 ready_out) else $error("ready timing");
	cov_push: cover property ($rose(dev_push_out));
	cov_pop: cover property ($rose(dev_pop_out));
	cov_clear: cover property ($fell(dev_clear_n_out));
endmodule // fth_host_sva

bind fth_host fth_host_sva u_sva (.clk_in, .rst_n_in, .rd_data_out, .rd_valid_out, .ready_out,
	.dev_data_out, .dev_push_out, .dev_space_available_in, .dev_data_in, .dev_pop_out,
	.dev_word_available_in, .dev_clear_n_out);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	// ********
	// clock, reset and wiring
	// ********
	localparam int W = fth_pkg::DATA_W;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic clear_req_in = 1'b0;
	logic wr_valid_in = 1'b0;
	logic rd_ready_in = 1'b0;
	logic slow = 1'b0;
	logic [W-1:0] wr_data_in = '0;
	logic [W-1:0] rd_data_out;
	logic [W-1:0] dev_dout;
	logic [W-1:0] dev_din;
	logic wr_ready_out, rd_valid_out, ready_out, dev_push, dev_pop, dev_clear_n, sp_av, wd_av;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	// free-running clock
	always #50 clk_in = ~clk_in;
	fth_host u_dut (.clk_in, .rst_n_in, .clear_req_in, .wr_data_in, .wr_valid_in, .wr_ready_out,
		.rd_data_out, .rd_valid_out, .rd_ready_in, .ready_out, .dev_data_out(dev_dout),
		.dev_push_out(dev_push), .dev_space_available_in(sp_av), .dev_data_in(dev_din),
		.dev_pop_out(dev_pop), .dev_word_available_in(wd_av), .dev_clear_n_out(dev_clear_n));
	fth_dev_model u_dev (.clk_in, .slow_in(slow), .clear_n_in(dev_clear_n), .push_in(dev_push),
		.data_in(dev_dout), .space_available_out(sp_av), .pop_in(dev_pop), .data_out(dev_din),
		.word_available_out(wd_av));
	task automatic check(input logic ok, input string msg);
		checked++;
		if (!ok) begin
			$display("FAIL %0t %s", $time, msg);
			bad_count++;
		end
	endtask
	// valid stays up on return; callers lower it
	task automatic put(input logic [W-1:0] w, output logic ok);
		int n = 0;
		wr_data_in <= w;
		wr_valid_in <= 1'b1;
		@(posedge clk_in);
		while (wr_ready_out !== 1'b1 && n < 200) begin
			n++;
			@(posedge clk_in);
		end
		ok = (wr_ready_out === 1'b1);
	endtask
	task automatic get(output logic [W-1:0] w);
		int n = 0;
		@(posedge clk_in);
		while (rd_valid_out !== 1'b1 && n < 400) begin
			n++;
			@(posedge clk_in);
		end
		w = rd_data_out;
	endtask
	task automatic s_init();
		int n = 0;
		@(posedge clk_in);
		check(dev_clear_n === 1'b0 && ready_out === 1'b0, "no clear after reset");
		while (ready_out !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_in);
		end
		check(ready_out === 1'b1 && sp_av === 1'b1 && wd_av === 1'b0, "not ready");
	endtask
	task automatic s_order();
		logic [W-1:0] w;
		logic ok;
		rd_ready_in <= 1'b1;
		put(5'h15, ok);
		put(5'h0a, ok);
		put(5'h1f, ok);
		wr_valid_in <= 1'b0;
		get(w);
		check(w === 5'h15, "first word");
		slow <= 1'b1;
		get(w);
		check(w === 5'h0a, "second word");
		get(w);
		check(w === 5'h1f, "third word");
		repeat (4) @(posedge clk_in);
		check(wd_av === 1'b0 && dev_din === 5'h1f, "last word lost");
	endtask
	task automatic s_fill();
		logic [W-1:0] w;
		logic ok = 1'b1;
		int cnt = 0;
		int lo = fth_pkg::DEV_DEPTH + fth_pkg::BUF_DEPTH + 1;
		rd_ready_in <= 1'b0;
		slow <= 1'b0;
		while (ok && cnt < 100) begin
			put(5'(cnt), ok);
			if (ok)
				cnt++;
		end
		wr_valid_in <= 1'b0;
		check(u_dev.mem_q.size() == 64 && sp_av === 1'b0, "device not full");
		check(cnt >= lo && cnt <= lo + 1, "fill count");
		slow <= 1'b1;
		rd_ready_in <= 1'b1;
		for (int i = 0; i < cnt; i++) begin
			get(w);
			check(w === 5'(i), "drain order");
		end
	endtask
	task automatic s_clear();
		logic [W-1:0] w;
		logic ok;
		int n = 0;
		rd_ready_in <= 1'b0;
		slow <= 1'b0;
		put(5'h03, ok);
		put(5'h0c, ok);
		wr_valid_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		clear_req_in <= 1'b1;
		while (dev_clear_n !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk_in);
		end
		clear_req_in <= 1'b0;
		@(posedge clk_in);
		check(sp_av === 1'b0 && wd_av === 1'b0 && u_dev.mem_q.size() == 0, "clear");
		n = 0;
		while (ready_out !== 1'b1 && n < 30) begin
			n++;
			@(posedge clk_in);
		end
		check(ready_out === 1'b1 && sp_av === 1'b1, "no space after clear");
		rd_ready_in <= 1'b1;
		repeat (40) @(posedge clk_in);
		put(5'h1b, ok);
		wr_valid_in <= 1'b0;
		get(w);
		check(w === 5'h1b, "word after clear");
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the longest expected run
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		s_init();
		s_order();
		s_fill();
		s_clear();
		tally_and_finish();
	end
endmodule // tb_top
